// file: verilog/modbus_slave_config_menu.sv
// Button-driven serial slave setup page with stored settings
`timescale 1ns/1ps
`include "mb_setup_regs.svh"
// Functional notes
// - Setup page shows stored enable, address, rate, parity, word order.
// - Up and down move the selection between parameter lines.
// - Right or OK opens edit page; login comes first if not logged in.
// - Left leaves the setup page back to the display menu.
// - Interface enabled means slave mode answering master requests.
// - Interface disabled hands the lines to sibling accessories.
// - Enable page: up/down toggle choice, right moves to commit commands.
// - Acknowledge only frames to own address, ignore the rest.
// - Slave address is kept within 1 to 255.
// - Address page: up/down change digit, left/right walk digits, cmds.
// - Commands: up/down pick Yes/No, OK stores or discards, back to page.
// - Speed limited to 4800, 9600, 19200, 38400, 57600, 115200.
// - Parity is even, odd or none.
// - Word order affects only double-word registers.
// - Word order big or little endian, big endian by default.
// - Edit page starts showing the stored value.
// - Speed page: up/down step rates, left/right go to commands.
// - Login holds in setup pages, cleared on home or lockout.
module modbus_slave_config_menu (
  input  wire logic              clk_sys,
  input  wire logic              srst,
  input  wire logic [`BTN_N-1:0] btn_pin,
  input  wire logic              menu_open,
  input  wire logic              setup_open,
  input  wire logic              lockout,
  input  wire logic              login_ok,
  input  wire logic              login_fail,
  input  wire logic              nv_load,
  input  wire logic [`NV_W-1:0]  nv_rd_data,
  input  wire logic              frame_valid,
  input  wire logic [7:0]        frame_addr,
  input  wire logic              resp_valid,
  input  wire logic              unsigned_double_word_format,
  input  wire logic [31:0]       resp_value,
  output mb_setup_pkg::page_t    page,
  output mb_setup_pkg::line_t    sel_line,
  output logic [1:0]             focus,
  output logic                   commit_yes,
  output mb_setup_pkg::cfg_t     edit,
  output mb_setup_pkg::cfg_t     stored,
  output logic                   logged_in,
  output logic                   nv_wr,
  output logic [`NV_W-1:0]       nv_wr_data,
  output logic [`DIV_W-1:0]      uart_div,
  output logic                   modbus_on,
  output logic                   accessory_on,
  output logic                   frame_ack,
  output logic                   acc_frame,
  output logic                   resp_out_valid,
  output logic [15:0]            resp_word0,
  output logic [15:0]            resp_word1
);
  logic [`BTN_N-1:0] press;
  logic up;
  logic dn;
  logic lf;
  logic rt;
  logic ok;
  logic leave;
  logic enter_edit;
  logic on_cmd;
  logic commit;
  logic [8:0] step;
  logic [8:0] addr_up;
  logic [8:0] addr_dn;

  cfg_if bus ();
  assign bus.cfg = stored;

  btn_sync u_btn (
    .clk_sys (clk_sys),
    .srst    (srst),
    .btn_pin (btn_pin),
    .press   (press)
  );

  mb_frame_gate u_gate (
    .clk_sys                     (clk_sys),
    .srst                        (srst),
    .cfg_in                      (bus),
    .frame_valid                 (frame_valid),
    .frame_addr                  (frame_addr),
    .resp_valid                  (resp_valid),
    .unsigned_double_word_format (unsigned_double_word_format),
    .resp_value                  (resp_value),
    .frame_ack                   (frame_ack),
    .acc_frame                   (acc_frame),
    .resp_out_valid              (resp_out_valid),
    .resp_word0                  (resp_word0),
    .resp_word1                  (resp_word1)
  );

  // Clock divisor for each permitted rate, rounded down
  function automatic logic [`DIV_W-1:0] baud_div(input logic [2:0] sel);
    int r;
    case (sel)
      3'h0:    r = `CLK_HZ / `BAUD_4800;
      3'h1:    r = `CLK_HZ / `BAUD_9600;
      3'h2:    r = `CLK_HZ / `BAUD_19200;
      3'h3:    r = `CLK_HZ / `BAUD_38400;
      3'h4:    r = `CLK_HZ / `BAUD_57600;
      default: r = `CLK_HZ / `BAUD_115200;
    endcase
    return r[`DIV_W-1:0];
  endfunction : baud_div

  // Weight of the focused address digit
  function automatic logic [8:0] digit_step(input logic [1:0] f);
    case (f)
      2'h0:    return 9'h064;
      2'h1:    return 9'h00a;
      default: return 9'h001;
    endcase
  endfunction : digit_step

  function automatic logic [`NV_W-1:0] pack_nv(
    input mb_setup_pkg::cfg_t c);
    logic [`NV_W-1:0] w;
    w = '0;
    w[`NV_EN_BIT] = c.enable;
    w[`NV_ADDR_LSB +: 8] = c.addr;
    w[`NV_BAUD_LSB +: 3] = c.baud;
    w[`NV_PAR_LSB +: 2] = c.parity;
    w[`NV_LE_BIT] = c.le;
    return w;
  endfunction : pack_nv

  assign up    = press[`BTN_UP];
  assign dn    = press[`BTN_DOWN];
  assign lf    = press[`BTN_LEFT];
  assign rt    = press[`BTN_RIGHT];
  assign ok    = press[`BTN_OK];
  assign leave = press[`BTN_HOME] | lockout;
  assign on_cmd = focus == `FOCUS_CMD;
  assign commit = page == mb_setup_pkg::PG_EDIT && on_cmd && ok && !leave;
  assign enter_edit = !leave && ((page == mb_setup_pkg::PG_SETUP
    && !lf && (rt || ok) && logged_in)
    || (page == mb_setup_pkg::PG_LOGIN && login_ok));

  // Saturating digit arithmetic keeps the address inside its range
  assign step    = digit_step(focus);
  assign addr_up = {1'b0, edit.addr} + step;
  assign addr_dn = {1'b0, edit.addr} - step;

  // Page flow
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      page <= mb_setup_pkg::PG_HOME;
    end else if (leave) begin
      page <= mb_setup_pkg::PG_HOME;
    end else begin
      case (page)
        mb_setup_pkg::PG_HOME: begin
          if (menu_open) page <= mb_setup_pkg::PG_MENU;
        end
        mb_setup_pkg::PG_MENU: begin
          if (setup_open) page <= mb_setup_pkg::PG_SETUP;
        end
        mb_setup_pkg::PG_SETUP: begin
          if (lf) begin
            page <= mb_setup_pkg::PG_MENU;
          end else if (rt || ok) begin
            page <= logged_in ? mb_setup_pkg::PG_EDIT
                              : mb_setup_pkg::PG_LOGIN;
          end
        end
        mb_setup_pkg::PG_LOGIN: begin
          if (login_ok) page <= mb_setup_pkg::PG_EDIT;
          else if (login_fail) page <= mb_setup_pkg::PG_SETUP;
        end
        mb_setup_pkg::PG_EDIT: begin
          if (commit) page <= mb_setup_pkg::PG_SETUP;
        end
        default: page <= mb_setup_pkg::PG_HOME;
      endcase
    end
  end

  // Line selection, restarted at the top on each entry from the display menu
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sel_line <= mb_setup_pkg::LN_IFACE;
    end else if (page == mb_setup_pkg::PG_MENU && setup_open) begin
      sel_line <= mb_setup_pkg::LN_IFACE;
    end else if (page == mb_setup_pkg::PG_SETUP && !leave) begin
      if (up && sel_line != mb_setup_pkg::LN_IFACE) begin
        sel_line <= mb_setup_pkg::line_t'(sel_line - 3'h1);
      end else if (dn && sel_line != `LINE_LAST) begin
        sel_line <= mb_setup_pkg::line_t'(sel_line + 3'h1);
      end
    end
  end

  // Login survives until home or lockout, including the display menu; clear wins over a late grant
  always_ff @(posedge clk_sys) begin
    if (srst || leave) begin
      logged_in <= 1'b0;
    end else if (page == mb_setup_pkg::PG_LOGIN && login_ok) begin
      logged_in <= 1'b1;
    end
  end

  // Focus and commit choice on the edit page
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      focus      <= 2'h0;
      commit_yes <= 1'b1;
    end else if (enter_edit) begin
      focus      <= 2'h0;
      commit_yes <= 1'b1;
    end else if (page == mb_setup_pkg::PG_EDIT && !leave) begin
      if (on_cmd) begin
        if (up || dn) commit_yes <= ~commit_yes;
        if (lf) begin
          focus <= sel_line == mb_setup_pkg::LN_ADDR
                   ? `DIGIT_LAST : 2'h0;
        end
      end else if (sel_line == mb_setup_pkg::LN_ADDR) begin
        if (rt) begin
          focus <= focus == `DIGIT_LAST ? `FOCUS_CMD
                                        : focus + 2'h1;
        end else if (lf && focus != 2'h0) begin
          focus <= focus - 2'h1;
        end
      end else if (rt) begin
        focus <= `FOCUS_CMD;
      end else if (lf && sel_line != mb_setup_pkg::LN_IFACE) begin
        focus <= `FOCUS_CMD;
      end
    end
  end

  // Working copy, loaded from the stored value on entry
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      edit <= '0;
    end else if (enter_edit) begin
      edit <= stored;
    end else if (page == mb_setup_pkg::PG_EDIT && !leave && !on_cmd) begin
      case (sel_line)
        mb_setup_pkg::LN_IFACE: begin
          if (up || dn) edit.enable <= ~edit.enable;
        end
        mb_setup_pkg::LN_ADDR: begin
          if (up) begin
            edit.addr <= addr_up > 9'h0ff ? `ADDR_MAX
                                          : addr_up[7:0];
          end else if (dn) begin
            edit.addr <= {1'b0, edit.addr} < step + 9'h001
                         ? `ADDR_MIN : addr_dn[7:0];
          end
        end
        mb_setup_pkg::LN_RATE: begin
          if (up && edit.baud != `BAUD_LAST) begin
            edit.baud <= edit.baud + 3'h1;
          end else if (dn && edit.baud != 3'h0) begin
            edit.baud <= edit.baud - 3'h1;
          end
        end
        mb_setup_pkg::LN_PARITY: begin
          if (up) begin
            edit.parity <= edit.parity == `PAR_LAST ? 2'h0
                           : edit.parity + 2'h1;
          end else if (dn) begin
            edit.parity <= edit.parity == 2'h0 ? `PAR_LAST
                           : edit.parity - 2'h1;
          end
        end
        mb_setup_pkg::LN_ORDER: begin
          if (up || dn) edit.le <= ~edit.le;
        end
        default: edit <= edit;
      endcase
    end
  end

  // Stored settings; a commit beats a late restore
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      stored.enable <= `DEF_ENABLE;
      stored.addr   <= `DEF_ADDR;
      stored.baud   <= `DEF_BAUD;
      stored.parity <= `DEF_PARITY;
      stored.le     <= `DEF_LE;
    end else if (commit && commit_yes) begin
      stored <= edit;
    end else if (nv_load) begin
      stored.enable <= nv_rd_data[`NV_EN_BIT];
      stored.addr   <= nv_rd_data[`NV_ADDR_LSB +: 8] == 8'h00
                       ? `ADDR_MIN : nv_rd_data[`NV_ADDR_LSB +: 8];
      stored.baud   <= nv_rd_data[`NV_BAUD_LSB +: 3] > `BAUD_LAST
                       ? `DEF_BAUD : nv_rd_data[`NV_BAUD_LSB +: 3];
      stored.parity <= nv_rd_data[`NV_PAR_LSB +: 2] > `PAR_LAST
                       ? `DEF_PARITY : nv_rd_data[`NV_PAR_LSB +: 2];
      stored.le     <= nv_rd_data[`NV_LE_BIT];
    end
  end

  // Nonvolatile write request, one cycle per Yes commit
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      nv_wr      <= 1'b0;
      nv_wr_data <= '0;
    end else begin
      nv_wr <= commit && commit_yes;
      if (commit && commit_yes) nv_wr_data <= pack_nv(edit);
    end
  end

  // Settings applied to the serial port
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      uart_div     <= baud_div(`DEF_BAUD);
      modbus_on    <= 1'b0;
      accessory_on <= 1'b0;
    end else begin
      uart_div     <= baud_div(stored.baud);
      modbus_on    <= stored.enable;
      accessory_on <= ~stored.enable;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  left_exit_a: assert property (
    page == mb_setup_pkg::PG_SETUP && lf && !leave
    |=> page == mb_setup_pkg::PG_MENU)
    else $error("left did not return to display menu");
  login_gate_a: assert property (
    page == mb_setup_pkg::PG_SETUP && (rt || ok) && !lf && !leave
    && !logged_in |=> page == mb_setup_pkg::PG_LOGIN)
    else $error("edit opened without login");
  login_clear_a: assert property (
    leave |=> !logged_in && page == mb_setup_pkg::PG_HOME)
    else $error("login kept after leaving setup pages");
  edit_load_a: assert property (
    enter_edit |=> edit == $past(stored) && focus == 2'h0)
    else $error("edit page not loaded with stored value");
  commit_store_a: assert property (
    commit && commit_yes |=> stored == $past(edit) && nv_wr
    && page == mb_setup_pkg::PG_SETUP)
    else $error("yes did not store and write");
  discard_a: assert property (
    commit && !commit_yes && !nv_load |=> stored == $past(stored)
    && !nv_wr && page == mb_setup_pkg::PG_SETUP)
    else $error("no did not discard");
  addr_range_a: assert property (
    stored.addr != 8'h00
    && (page != mb_setup_pkg::PG_EDIT || edit.addr != 8'h00))
    else $error("slave address left its range");
  rate_range_a: assert property (
    stored.baud <= `BAUD_LAST ##1 uart_div == baud_div($past(stored.baud)))
    else $error("rate outside permitted set");
  mode_split_a: assert property (
    1'b1 |=> modbus_on != accessory_on && modbus_on == $past(stored.enable))
    else $error("bus mode does not follow enable");
endmodule : modbus_slave_config_menu

// file: verilog/mb_setup_regs.svh
// Reset values, field positions and timing counts of the setup page
`ifndef MB_SETUP_REGS_SVH
`define MB_SETUP_REGS_SVH
`define CLK_HZ       10000000
`define BAUD_4800    4800
`define BAUD_9600    9600
`define BAUD_19200   19200
`define BAUD_38400   38400
`define BAUD_57600   57600
`define BAUD_115200  115200
`define BTN_N        6
`define BTN_UP       0
`define BTN_DOWN     1
`define BTN_LEFT     2
`define BTN_RIGHT    3
`define BTN_OK       4
`define BTN_HOME     5
`define LINE_LAST    3'h4
`define BAUD_LAST    3'h5
`define PAR_LAST     2'h2
`define ADDR_MIN     8'h01
`define ADDR_MAX     8'hff
`define DIGIT_LAST   2'h2
`define FOCUS_CMD    2'h3
`define DEF_ENABLE   1'h1
`define DEF_ADDR     8'h01
`define DEF_BAUD     3'h1
`define DEF_PARITY   2'h0
`define DEF_LE       1'h0
`define NV_EN_BIT    0
`define NV_ADDR_LSB  1
`define NV_BAUD_LSB  9
`define NV_PAR_LSB   12
`define NV_LE_BIT    14
`define NV_W         15
`define DIV_W        12
`endif

// file: verilog/mb_setup_pkg.sv
// Types shared by the serial setup page modules
package mb_setup_pkg;
  typedef enum logic [2:0] {
    PG_HOME, PG_MENU, PG_SETUP, PG_LOGIN, PG_EDIT
  } page_t;
  typedef enum logic [2:0] {
    LN_IFACE, LN_ADDR, LN_RATE, LN_PARITY, LN_ORDER
  } line_t;
  typedef enum logic [1:0] {PAR_NONE, PAR_EVEN, PAR_ODD} parity_t;
  typedef struct packed {
    logic       le;
    logic [1:0] parity;
    logic [2:0] baud;
    logic [7:0] addr;
    logic       enable;
  } cfg_t;
endpackage : mb_setup_pkg

// file: verilog/cfg_if.sv
// Stored serial settings passed to the frame gate
`timescale 1ns/1ps
interface cfg_if;
  mb_setup_pkg::cfg_t cfg;
  modport src (output cfg);
  modport dst (input cfg);
endinterface : cfg_if

// file: verilog/btn_sync.sv
// Button synchroniser and press detector
`timescale 1ns/1ps
`include "mb_setup_regs.svh"
module btn_sync (
  input  wire logic              clk_sys,
  input  wire logic              srst,
  input  wire logic [`BTN_N-1:0] btn_pin,
  output logic      [`BTN_N-1:0] press
);
  logic [`BTN_N-1:0] s1;
  logic [`BTN_N-1:0] s2;
  logic [`BTN_N-1:0] s3;

  genvar i;
  generate
    for (i = 0; i < `BTN_N; i++) begin : g_btn
      always_ff @(posedge clk_sys) begin
        if (srst) begin
          s1[i]    <= 1'b0;
          s2[i]    <= 1'b0;
          s3[i]    <= 1'b0;
          press[i] <= 1'b0;
        end else begin
          s1[i]    <= btn_pin[i];
          s2[i]    <= s1[i];
          s3[i]    <= s2[i];
          press[i] <= s2[i] & ~s3[i];
        end
      end
    end
  endgenerate
endmodule : btn_sync

// file: verilog/mb_frame_gate.sv
// Address filter, bus mode split and 32-bit word ordering
`timescale 1ns/1ps
`include "mb_setup_regs.svh"
module mb_frame_gate (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  cfg_if.dst               cfg_in,
  input  wire logic        frame_valid,
  input  wire logic [7:0]  frame_addr,
  input  wire logic        resp_valid,
  input  wire logic        unsigned_double_word_format,
  input  wire logic [31:0] resp_value,
  output logic             frame_ack,
  output logic             acc_frame,
  output logic             resp_out_valid,
  output logic [15:0]      resp_word0,
  output logic [15:0]      resp_word1
);
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      frame_ack <= 1'b0;
      acc_frame <= 1'b0;
    end else begin
      frame_ack <= frame_valid & cfg_in.cfg.enable
                 & (frame_addr == cfg_in.cfg.addr);
      acc_frame <= frame_valid & ~cfg_in.cfg.enable;
    end
  end

  // Only double-word registers swap; single words pass as word1
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      resp_out_valid <= 1'b0;
      resp_word0     <= 16'h0000;
      resp_word1     <= 16'h0000;
    end else begin
      resp_out_valid <= resp_valid & cfg_in.cfg.enable;
      if (resp_valid) begin
        if (unsigned_double_word_format && cfg_in.cfg.le) begin
          resp_word0 <= resp_value[15:0];
          resp_word1 <= resp_value[31:16];
        end else begin
          resp_word0 <= resp_value[31:16];
          resp_word1 <= resp_value[15:0];
        end
      end
    end
  end

  ack_match_a: assert property (@(posedge clk_sys) disable iff (srst)
    frame_valid && frame_addr != cfg_in.cfg.addr |=> !frame_ack)
    else $error("frame for another slave was acknowledged");
  word_order_a: assert property (@(posedge clk_sys) disable iff (srst)
    resp_valid && unsigned_double_word_format && !cfg_in.cfg.le
    |=> resp_word0 == $past(resp_value[31:16]))
    else $error("big-endian high word not sent first");
endmodule : mb_frame_gate

// file: dv/modbus_master_model.sv
// Bus master model issuing frames and 32-bit responses to the gate
`timescale 1ns/1ps
module modbus_master_model (
  input  wire logic   clk_sys,
  output logic        frame_valid,
  output logic [7:0]  frame_addr,
  output logic        resp_valid,
  output logic        unsigned_double_word_format,
  output logic [31:0] resp_value
);
  initial begin
    frame_valid = 1'h0;
    frame_addr = 8'h5a;
    resp_valid = 1'h0;
    unsigned_double_word_format = 1'h0;
    resp_value = 32'ha5a5a5a5;
  end
  // Lines are scrambled after the strobe so stale values never match
  task automatic send_frame(input logic [7:0] a);
    @(posedge clk_sys);
    #1;
    frame_valid = 1'h1;
    frame_addr = a;
    @(posedge clk_sys);
    #1;
    frame_valid = 1'h0;
    frame_addr = ~a;
  endtask : send_frame
  task automatic send_resp(input logic u, input logic [31:0] v);
    @(posedge clk_sys);
    #1;
    resp_valid = 1'h1;
    unsigned_double_word_format = u;
    resp_value = v;
    @(posedge clk_sys);
    #1;
    resp_valid = 1'h0;
    unsigned_double_word_format = ~u;
    resp_value = ~v;
  endtask : send_resp
endmodule : modbus_master_model

// file: dv/modbus_slave_config_menu_tb_top.sv
// Self-checking bench for the serial slave setup page
`timescale 1ns/1ps
`include "mb_setup_regs.svh"
module modbus_slave_config_menu_tb_top;
  logic clk_sys, srst, menu_open, setup_open, lockout;
  logic login_ok, login_fail, nv_load;
  logic [`BTN_N-1:0] btn_pin;
  logic [`NV_W-1:0] nv_rd_data, nv_wr_data, nv_seen;
  logic frame_valid, resp_valid, unsigned_double_word_format;
  logic [7:0] frame_addr;
  logic [31:0] resp_value;
  mb_setup_pkg::page_t page;
  mb_setup_pkg::line_t sel_line;
  mb_setup_pkg::cfg_t edit, stored;
  logic [1:0] focus;
  logic commit_yes, logged_in, nv_wr, modbus_on, accessory_on;
  logic frame_ack, acc_frame, resp_out_valid;
  logic [15:0] resp_word0, resp_word1;
  logic [`DIV_W-1:0] uart_div;
  int checks = 0;
  int miscompares = 0;
  int unsigned rates [6] = '{32'h12c0, 32'h2580, 32'h4b00, 32'h9600,
                             32'he100, 32'h1c200};

  modbus_slave_config_menu dut (.clk_sys, .srst, .btn_pin, .menu_open,
    .setup_open, .lockout, .login_ok, .login_fail, .nv_load, .nv_rd_data,
    .frame_valid, .frame_addr, .resp_valid, .unsigned_double_word_format,
    .resp_value, .page, .sel_line, .focus, .commit_yes, .edit, .stored,
    .logged_in, .nv_wr, .nv_wr_data, .uart_div, .modbus_on, .accessory_on,
    .frame_ack, .acc_frame, .resp_out_valid, .resp_word0, .resp_word1);
  modbus_master_model mst (.clk_sys, .frame_valid, .frame_addr, .resp_valid,
    .unsigned_double_word_format, .resp_value);

  initial begin
    clk_sys = 1'h0;
    forever #50 clk_sys = ~clk_sys;
  end
  // Store writes are single-cycle pulses, so capture them as they pass
  always @(posedge clk_sys) if (nv_wr === 1'h1) nv_seen <= nv_wr_data;

  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic pulse(ref logic s);
    s = 1'h1;
    tick;
    s = 1'h0;
    tick;
  endtask : pulse
  // Pin held two cycles then low, well past the three-edge sync delay
  task automatic press(input int b);
    btn_pin[b] = 1'h1;
    repeat (2) tick;
    btn_pin[b] = 1'h0;
    repeat (6) tick;
  endtask : press
  task automatic to_line(input int n);
    for (int i = 0; i < 5 && sel_line != n; i++)
      press(sel_line < n ? `BTN_DOWN : `BTN_UP);
    press(`BTN_OK);
  endtask : to_line
  task automatic commit(input logic yes);
    for (int i = 0; i < 4 && focus !== 2'h3; i++) press(`BTN_RIGHT);
    for (int i = 0; i < 2 && commit_yes !== yes; i++) press(`BTN_UP);
    press(`BTN_OK);
    chk(page, mb_setup_pkg::PG_SETUP);
  endtask : commit
  task automatic complete_run;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run

  task automatic scen_nav_login;
    pulse(menu_open);
    pulse(setup_open);
    chk(page, mb_setup_pkg::PG_SETUP);
    repeat (5) press(`BTN_DOWN);
    chk(sel_line, 3'h4);
    press(`BTN_LEFT);
    chk(page, mb_setup_pkg::PG_MENU);
    pulse(setup_open);
    press(`BTN_RIGHT);
    chk(page, mb_setup_pkg::PG_LOGIN);
    pulse(login_ok);
    chk({page, logged_in}, {mb_setup_pkg::PG_EDIT, 1'h1});
    chk(edit, 15'h0203);
    chk(commit_yes, 1'h1);
    press(`BTN_UP);
    chk(edit.enable, 1'h0);
    press(`BTN_RIGHT);
    chk(focus, 2'h3);
    commit(1'h0);
    chk(stored, 15'h0203);
  endtask : scen_nav_login
  task automatic scen_addr;
    to_line(1);
    chk({page, edit.addr}, {mb_setup_pkg::PG_EDIT, 8'h01});
    repeat (3) press(`BTN_UP);
    chk(edit.addr, 8'hff);
    repeat (3) press(`BTN_DOWN);
    chk(edit.addr, 8'h01);
    press(`BTN_UP);
    press(`BTN_RIGHT);
    press(`BTN_UP);
    press(`BTN_RIGHT);
    press(`BTN_DOWN);
    press(`BTN_RIGHT);
    press(`BTN_LEFT);
    chk({focus, edit.addr}, {2'h2, 8'h6e});
    commit(1'h1);
    chk(stored.addr, 8'h6e);
    chk(nv_seen, 15'h02dd);
    mst.send_frame(8'h6e);
    chk({frame_ack, acc_frame}, 2'h2);
    mst.send_frame(8'h6f);
    chk({frame_ack, acc_frame}, 2'h0);
  endtask : scen_addr
  task automatic scen_rate_parity;
    for (int i = 0; i < 6; i++) begin
      to_line(2);
      press(i == 0 ? `BTN_DOWN : `BTN_UP);
      commit(1'h1);
      chk(stored.baud, i);
      chk(uart_div, 32'h989680 / rates[i]);
    end
    to_line(2);
    press(`BTN_UP);
    chk(edit.baud, 3'h5);
    press(`BTN_LEFT);
    chk(focus, 2'h3);
    commit(1'h0);
    chk(nv_seen, 15'h0add);
    to_line(3);
    chk(edit.parity, 2'h0);
    for (int i = 1; i < 4; i++) begin
      press(`BTN_UP);
      chk(edit.parity, i % 3);
    end
    press(`BTN_DOWN);
    commit(1'h1);
    chk(stored.parity, mb_setup_pkg::PAR_ODD);
  endtask : scen_rate_parity
  task automatic scen_order;
    mst.send_resp(1'h1, 32'h12345678);
    chk({resp_out_valid, resp_word0, resp_word1}, 33'h112345678);
    to_line(4);
    chk(edit.le, 1'h0);
    press(`BTN_DOWN);
    commit(1'h1);
    chk(stored.le, 1'h1);
    mst.send_resp(1'h1, 32'h12345678);
    chk({resp_out_valid, resp_word0, resp_word1}, 33'h156781234);
    mst.send_resp(1'h0, 32'h12345678);
    chk({resp_word0, resp_word1}, 32'h12345678);
  endtask : scen_order
  task automatic scen_disable_lock;
    to_line(0);
    press(`BTN_DOWN);
    commit(1'h1);
    repeat (2) tick;
    chk({modbus_on, accessory_on}, 2'h1);
    mst.send_frame(8'h6e);
    chk({frame_ack, acc_frame}, 2'h1);
    mst.send_resp(1'h0, 32'h0000ffff);
    chk(resp_out_valid, 1'h0);
    lockout = 1'h1;
    repeat (2) tick;
    chk({page, logged_in}, {mb_setup_pkg::PG_HOME, 1'h0});
    lockout = 1'h0;
    pulse(menu_open);
    pulse(setup_open);
    press(`BTN_OK);
    chk(page, mb_setup_pkg::PG_LOGIN);
    pulse(login_fail);
    chk(logged_in, 1'h0);
    // Bad restore image: zero address raised to 1, rate 7 and parity 3 fall back to defaults
    nv_rd_data = {1'h1, 2'h3, 3'h7, 8'h00, 1'h1};
    pulse(nv_load);
    tick;
    chk({stored, uart_div}, {15'h4203, 12'h411});
  endtask : scen_disable_lock

  initial begin
    srst = 1'h1;
    btn_pin = '0;
    {menu_open, setup_open, lockout, login_ok, login_fail, nv_load} = '0;
    nv_rd_data = '0;
    repeat (8) tick;
    srst = 1'h0;
    repeat (3) tick;
    chk({stored, uart_div}, {15'h0203, 12'h411});
    chk({page, modbus_on, accessory_on}, 5'h02);
    scen_nav_login;
    scen_addr;
    scen_rate_parity;
    scen_order;
    scen_disable_lock;
    complete_run;
  end
  // Whole run is under a thousand cycles; the limit leaves wide margin
  initial begin
    repeat (40000) @(posedge clk_sys);
    miscompares++;
    complete_run;
  end
endmodule : modbus_slave_config_menu_tb_top
